/* core/acrf_pkg.sv */
// Shared constants and types for the converter control and result format block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
package acrf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFS   = 4'h0; // Converter control register.
	localparam logic [3:0] RESH_OFS   = 4'h4; // High result register.
	localparam logic [3:0] RESL_OFS   = 4'h8; // Low result register.
	localparam logic [3:0] STATUS_OFS = 4'hc; // Block state register.
	localparam logic [7:0] CTRL_RST   = 8'h00; // Control reset value.

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int PWR_BIT  = 7; // Power up bit.
	localparam int JUST_BIT = 6; // Justify select.
	localparam int RES_BIT  = 5; // Resolution select.
	localparam int SGN_BIT  = 4; // Signed select.
	localparam int PRS_MSB  = 3; // Prescale select top bit.

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0; // Normal answer.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped address.

	// Decoded control fields.
	typedef struct packed
	{
		logic       power_up_bit;
		logic       justify_select;
		logic       resolution_select;
		logic       signed_select;
		logic [3:0] clock_prescale_select;
	} acrf_ctrl_s;

	// Formatted result pair.
	typedef struct packed
	{
		logic [7:0] result_high;
		logic [7:0] result_low;
	} acrf_result_s;

endpackage

/* core/acrf_top.sv */
// Control register, result formatter and conversion clock prescaler
// of a 10-bit successive-approximation converter.
// Assumes the analog path raises conv_done with a raw 10-bit code, and
// that the status register logic drives start_req, both on aclk.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.

module acrf_top
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address and data.
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Status register side and analog path.
	input  wire logic        start_req,
	input  wire logic        conv_done,
	input  wire logic [9:0]  conv_code,
	output logic             conv_abort,
	output logic             conv_start,
	output logic             conv_busy,
	output logic             conv_clk_en,
	output logic             done_flag
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	acrf_pkg::acrf_ctrl_s   ctrl_r;     // Converter control register.
	acrf_pkg::acrf_result_s result_r;   // Formatted result registers.
	logic                   aw_held_r;  // Write address captured.
	logic                   w_held_r;   // Write data captured.
	logic [3:0]             aw_addr_r;  // Captured write offset.
	logic [7:0]             w_data_r;   // Captured low data byte.
	logic                   w_lane_r;   // Low byte lane enabled.
	logic [4:0]             div_cnt_r;  // Prescale counter.
	logic                   ctrl_wr;    // Control write this cycle.
	logic                   wr_go;      // Write performed this cycle.
	logic                   rd_go;      // Read taken this cycle.
	logic [3:0]             rd_ofs;     // Read offset.
	logic [4:0]             div_max;    // Last count of a period.
	acrf_pkg::acrf_result_s fmt;        // Result about to be stored.

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------

	// Address and data are taken independently, in either order.
	assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
	assign ctrl_wr = wr_go && aw_addr_r == acrf_pkg::CTRL_OFS && w_lane_r;

	// Capture write address.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr[3:0];
		end
		else if (wr_go)
		begin
			aw_held_r <= 1'b0;
		end
	end

	// Capture write data.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata[7:0];
			w_lane_r <= s_axi_wstrb[0];
		end
		else if (wr_go)
		begin
			w_held_r <= 1'b0;
		end
	end

	// Ready is high while the matching slot is empty and no write response is pending.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end

	// Write response; only the four word offsets are mapped.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= acrf_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr_r == acrf_pkg::CTRL_OFS ||
				aw_addr_r == acrf_pkg::RESH_OFS ||
				aw_addr_r == acrf_pkg::RESL_OFS ||
				aw_addr_r == acrf_pkg::STATUS_OFS)
				? acrf_pkg::RESP_OKAY : acrf_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register; result and status words are read-only.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= acrf_pkg::acrf_ctrl_s'(acrf_pkg::CTRL_RST);
		end
		else if (ctrl_wr)
		begin
			ctrl_r <= acrf_pkg::acrf_ctrl_s'(w_data_r);
		end
	end

	// ----------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------

	// Abort, start and busy tracking for the analog path.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			conv_abort <= 1'b1;
			conv_start <= 1'b0;
			conv_busy  <= 1'b0;
		end
		else
		begin
			// A control write or powered-down state aborts.
			conv_abort <= ctrl_wr || !ctrl_r.power_up_bit;
			// Only a status write starts a conversion, never a control write.
			conv_start <= start_req && ctrl_r.power_up_bit && !ctrl_wr;
			if (ctrl_wr || !ctrl_r.power_up_bit)
			begin
				conv_busy <= 1'b0;
			end
			else if (start_req)
			begin
				conv_busy <= 1'b1;
			end
			else if (conv_done)
			begin
				conv_busy <= 1'b0;
			end
		end
	end

	// Completion flag; a new completion wins over a clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_flag <= 1'b0;
		end
		else if (conv_done && conv_busy && !ctrl_wr && ctrl_r.power_up_bit)
		begin
			done_flag <= 1'b1;
		end
		else if (start_req || (rd_go && (rd_ofs == acrf_pkg::RESH_OFS ||
			rd_ofs == acrf_pkg::RESL_OFS)))
		begin
			done_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Result formatting
	// ----------------------------------------------------------------

	// Map the raw code onto the result pair.
	always_comb
	begin
		fmt = '0;
		if (ctrl_r.resolution_select)
		begin
			// Eight-bit result is always in the high register.
			fmt.result_high = conv_code[9:2];
			// Signed only while left justified.
			if (ctrl_r.signed_select && !ctrl_r.justify_select)
			begin
				fmt.result_high[7] = ~conv_code[9];
			end
		end
		else if (ctrl_r.justify_select)
		begin
			// Right justified: signed select is ignored.
			fmt.result_high = {6'h00, conv_code[9:8]};
			fmt.result_low  = conv_code[7:0];
		end
		else
		begin
			// Left justified ten-bit layout.
			fmt.result_high = conv_code[9:2];
			fmt.result_low  = {conv_code[1:0], 6'h00};
			if (ctrl_r.signed_select)
			begin
				fmt.result_high[7] = ~conv_code[9];
			end
		end
	end

	// Results update only on a completion that was not aborted.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			result_r <= '0;
		end
		else if (conv_done && conv_busy && !ctrl_wr && ctrl_r.power_up_bit)
		begin
			result_r <= fmt;
		end
	end

	// ----------------------------------------------------------------
	// Conversion clock prescaler
	// ----------------------------------------------------------------

	// One enable pulse every (select+1)*2 bus clocks.
	assign div_max = 5'({ctrl_r.clock_prescale_select, 1'b1});

	// Counter runs only while powered up; restarts on a control write.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt_r   <= 5'h00;
			conv_clk_en <= 1'b0;
		end
		else if (!ctrl_r.power_up_bit || ctrl_wr)
		begin
			div_cnt_r   <= 5'h00;
			conv_clk_en <= 1'b0;
		end
		else if (div_cnt_r >= div_max)
		begin
			div_cnt_r   <= 5'h00;
			conv_clk_en <= 1'b1;
		end
		else
		begin
			div_cnt_r   <= div_cnt_r + 5'h01;
			conv_clk_en <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign rd_go  = s_axi_arvalid && s_axi_arready;
	assign rd_ofs = s_axi_araddr[3:0];

	// Address ready while no read answer is outstanding.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
		end
	end

	// Read data and response.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= acrf_pkg::RESP_OKAY;
		end
		else if (rd_go)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= acrf_pkg::RESP_OKAY;
			unique case (rd_ofs)
				acrf_pkg::CTRL_OFS:
					s_axi_rdata <= {24'h000000, ctrl_r};
				acrf_pkg::RESH_OFS:
					s_axi_rdata <= {24'h000000, result_r.result_high};
				acrf_pkg::RESL_OFS:
					s_axi_rdata <= {24'h000000, result_r.result_low};
				acrf_pkg::STATUS_OFS:
					s_axi_rdata <= {29'h00000000, conv_clk_en,
						conv_busy, done_flag};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= acrf_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

/* tb/acrf_monitor.sv */
// Concurrent checks on the ports of the converter control block.
// Assumes one clock, aclk, and the synchronous active-low reset aresetn.
module acrf_monitor
(
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Conversion side.
	input wire logic        start_req,
	input wire logic        conv_done,
	input wire logic [9:0]  conv_code,
	input wire logic        conv_abort,
	input wire logic        conv_start,
	input wire logic        conv_busy,
	input wire logic        conv_clk_en,
	input wire logic        done_flag
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Address and data of the write taken together.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// A whole write aimed at the control word.
	sequence ctrl_wr;
		wr_taken ##0 (s_axi_awaddr[3:0] == acrf_pkg::CTRL_OFS)
			&& s_axi_wstrb[0];
	endsequence

	chk_wr_abort: assert property (ctrl_wr |-> ##2 conv_abort)
		else $error("no abort after control write");
	chk_abort_nostart: assert property (conv_abort |-> !conv_start)
		else $error("start while aborted");
	chk_start_cause: assert property (conv_start |-> $past(start_req))
		else $error("start without request");
	chk_done_cause: assert property ($rose(done_flag) |->
		$past(conv_done) && !conv_busy)
		else $error("flag set without completion");
	chk_clk_pulse: assert property (conv_clk_en |=> !conv_clk_en)
		else $error("clock enable longer than one cycle");
	// Both halves are held one cycle before the response is registered.
	chk_b_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read not answered");
	chk_bad_addr: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr[1:0] != 2'h0 |=> s_axi_rdata == 32'h0
		&& s_axi_rresp == acrf_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	chk_high_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
endmodule

bind acrf_top acrf_monitor i_mon (.*);

/* tb/tb.sv */
// Self-checking bench for the converter control block.
// Assumes the bench alone drives every input of acrf_top.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, start_req;
	logic        conv_done, conv_abort, conv_start, conv_busy, conv_clk_en;
	logic        done_flag;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
	logic [9:0]  conv_code, k;
	logic [7:0]  c;
	logic [15:0] e;
	int          failures, comparisons;
	acrf_top i_dut (.*);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Compares one value with its expectation.
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x)
		begin
			failures++;
			$display("wrong value at %0t: %h, want %h", $time, s, x);
		end
	endtask

	// Reference result format: high and low bytes.
	function automatic logic [15:0] fmt(input logic [7:0] f,
		input logic [9:0] v);
		v[9] = v[9] ^ (f[4] & ~f[6]);
		if (f[5])
			return {v[9:2], 8'h00};
		return f[6] ? {6'h00, v} : {v, 6'h00};
	endfunction

	// One register write; each channel is released when taken.
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= {28'h0, a};
		s_axi_wdata <= {24'h0, x};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; s_axi_bvalid !== 1'b1; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (n > 40)
			begin
				failures++;
				end_of_test();
			end
		end
		// The response code is taken at the edge that sees bvalid.
		b = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// One register read, data and response taken at the answer.
	task automatic rd(input logic [3:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr <= {28'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; s_axi_rvalid !== 1'b1; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (n > 40)
			begin
				failures++;
				end_of_test();
			end
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Cycles from one conversion clock pulse to the next.
	task automatic presc(input int f);
		int n;
		for (n = 0; conv_clk_en !== 1'b1 && n < 99; n++)
			@(posedge aclk);
		@(posedge aclk);
		for (n = 1; conv_clk_en !== 1'b1 && n < 99; n++)
			@(posedge aclk);
		chk(n, f);
	endtask

	// Start request, optional control write, then completion.
	task automatic conv(input logic [9:0] v, input logic ab);
		@(posedge aclk);
		start_req <= 1'b1;
		@(posedge aclk);
		start_req <= 1'b0;
		if (ab)
			wr(acrf_pkg::CTRL_OFS, c);
		repeat (2) @(posedge aclk);
		conv_code <= v;
		conv_done <= 1'b1;
		@(posedge aclk);
		conv_done <= 1'b0;
		@(posedge aclk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Clock and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial
	begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, start_req, conv_done} = '0;
		{aresetn, conv_code} = '0;
		s_axi_wstrb = 4'h1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		void'($urandom(32'h70ed));
		rd(acrf_pkg::CTRL_OFS);
		chk(d, acrf_pkg::CTRL_RST);
		rd(4'h2);
		chk(r, acrf_pkg::RESP_SLVERR);
		// An unaligned write is refused and leaves the control word alone.
		wr(4'h1, 8'hff);
		chk(b, acrf_pkg::RESP_SLVERR);
		rd(acrf_pkg::CTRL_OFS);
		chk(d, acrf_pkg::CTRL_RST);
		// Every format setting at full scale, zero and a random code.
		for (int i = 0; i < 24; i++)
		begin
			// Prescale is random: at this bus clock no code keeps the
			// conversion clock under its ceiling, so only the ratio is checked.
			c = {1'b1, 3'(i), 4'($urandom_range(15))};
			k = (i < 8) ? 10'h3ff : (i < 16) ? 10'h000 : 10'($urandom);
			wr(acrf_pkg::CTRL_OFS, c);
			chk(b, acrf_pkg::RESP_OKAY);
			presc((c[3:0] + 1) * 2);
			conv(k, 1'b0);
			chk(done_flag, 1'b1);
			e = fmt(c, k);
			rd(acrf_pkg::RESH_OFS);
			chk(d, e[15:8]);
			rd(acrf_pkg::RESL_OFS);
			chk(d, e[7:0]);
			@(posedge aclk);
			#1;
			chk(done_flag, 1'b0);
		end
		// A status write alone clears the flag and starts a conversion.
		conv(10'h2aa, 1'b0);
		chk(done_flag, 1'b1);
		@(posedge aclk);
		start_req <= 1'b1;
		@(posedge aclk);
		start_req <= 1'b0;
		@(posedge aclk);
		#1;
		chk({done_flag, conv_busy}, 2'h1);
		// Control write during a conversion ends it and starts none.
		conv(10'h155, 1'b1);
		chk({done_flag, conv_busy}, 2'h0);
		// Powered down: requests are refused, abort stays high.
		c = 8'h30;
		wr(acrf_pkg::CTRL_OFS, c);
		conv(10'h3ff, 1'b0);
		chk({done_flag, conv_busy, conv_abort}, 3'h1);
		// Powered down: status shows no flag, no busy, no clock enable.
		rd(acrf_pkg::STATUS_OFS);
		chk(d, 32'h0000_0000);
		end_of_test();
	end
endmodule
